//--- rtl/adcc_pkg.sv
// adcc_pkg: address map, field layout, timing and state types of the converter control block
package adcc_pkg;

   // ****************************************
   // register map
   // ****************************************
   localparam logic [7:0] RESULT_ADDR = 8'h70;
   localparam logic [7:0] CSR_ADDR = 8'h71;
   localparam logic [7:0] EVT_ADDR = 8'h72;
   localparam logic [7:0] MASK_ADDR = 8'h73;
   localparam logic [7:0] REG_RESET = 8'h00;

   // ****************************************
   // control/status fields
   // ****************************************
   localparam int COCO_BIT = 7;
   localparam int RSV6_BIT = 6;
   localparam int ON_BIT = 5;
   localparam int ZERO4_BIT = 4;
   localparam int RSV3_BIT = 3;
   localparam int CH_W = 3;

   // ****************************************
   // event bits
   // ****************************************
   localparam int EVT_ABORT = 0;
   localparam int EVT_OVERRUN = 1;
   localparam int EVT_READY = 2;
   localparam int EVT_W = 3;

   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_PERIOD_PS = 5000;
   localparam int STAB_TIME_NS = 30000;
   // least time, rounded up to whole cycles
   localparam int STAB_CYC = (STAB_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int STAB_W = 16;
   localparam int CONV_CYC = 64;
   // sampling lasts 31.5 cycles, counted in half cycles and rounded up
   localparam int SAMPLE_HALF_CYC = 63;
   localparam int SAMPLE_CYC = (SAMPLE_HALF_CYC + 1) / 2;
   localparam int BIT_SH = 2;
   localparam int BIT_CYC = 4;
   localparam int CNT_W = 6;
   localparam int SAR_W = 8;
   localparam logic [7:0] SAR_MSB = 8'h80;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_STAB = 2'b01,
      ST_SAMPLE = 2'b11,
      ST_CONVERT = 2'b10
   } adcc_state_t;

   typedef struct packed {
      adcc_state_t state;
      logic [CNT_W-1:0] cnt;
      logic [STAB_W-1:0] stab;
      logic on;
      logic [CH_W-1:0] chan;
      logic coco;
      logic [SAR_W-1:0] result;
      logic [SAR_W-1:0] sar;
      logic [EVT_W-1:0] evt;
      logic [EVT_W-1:0] mask;
      logic cmp_s1;
      logic cmp_s2;
      logic [7:0] rdata;
      logic irq;
      logic sample;
      logic pwr;
   } adcc_regs_t;

endpackage : adcc_pkg

//--- rtl/adcc_top.sv
// adcc_top: register interface and successive approximation sequencer of the 8-bit converter
`timescale 1ns/1ps
`default_nettype none

module adcc_top #(
   parameter int unsigned STAB_CYCLES = adcc_pkg::STAB_CYC
) (
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // chip power state
   input wire logic halt,
   // analog front end
   input wire logic cmp_hi,
   output logic [adcc_pkg::CH_W-1:0] channel_select,
   output logic [adcc_pkg::SAR_W-1:0] trial_code,
   output logic sample_en,
   output logic converter_power,
   // interrupt
   output logic irq
);
   import adcc_pkg::*;

   adcc_regs_t s;
   adcc_regs_t n;
   logic wr_csr;
   logic rd_res;
   logic wr_evt;
   logic wr_mask;
   logic last_slot;
   logic done;
   logic [CH_W-1:0] bit_idx;
   logic [BIT_SH-1:0] phase;
   logic [SAR_W-1:0] sar_dec;
   logic [EVT_W-1:0] evt_set;
   logic [EVT_W-1:0] evt_clr;
   logic [CNT_W-1:0] age_r;

   // ****************************************
   // register port decode
   // ****************************************
   assign wr_csr = reg_wr && (reg_addr == CSR_ADDR);
   assign rd_res = reg_rd && (reg_addr == RESULT_ADDR);
   assign wr_evt = reg_wr && (reg_addr == EVT_ADDR);
   assign wr_mask = reg_wr && (reg_addr == MASK_ADDR);

   // ****************************************
   // sequencer slot decode
   // ****************************************
   assign phase = s.cnt[BIT_SH-1:0];
   // convert slots 32..63 map to bits 7..0, msb first
   assign bit_idx = CH_W'(~(s.cnt >> BIT_SH));
   assign last_slot = (s.cnt == CNT_W'(CONV_CYC - 1));
   // a control/status write or halt in the final slot wins: that conversion is thrown away
   assign done = (s.state == ST_CONVERT) && last_slot && !wr_csr && !halt;

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      n = s;
      sar_dec = s.sar;
      evt_set = '0;
      evt_clr = '0;
      // comparator is asynchronous to mclk
      n.cmp_s1 = cmp_hi;
      n.cmp_s2 = s.cmp_s1;

      // read data stand for one cycle only
      n.rdata = REG_RESET;
      if (reg_rd) begin
         case (reg_addr)
            RESULT_ADDR: begin
               n.rdata = s.result;
            end
            CSR_ADDR: begin
               n.rdata = {s.coco, 1'b0, s.on, 1'b0, 1'b0, s.chan};
            end
            EVT_ADDR: begin
               n.rdata = 8'(s.evt);
            end
            MASK_ADDR: begin
               n.rdata = 8'(s.mask);
            end
            default: begin
               n.rdata = REG_RESET;
            end
         endcase
      end

      // software side of control/status
      if (rd_res || wr_csr) begin
         n.coco = 1'b0;
      end
      if (wr_csr) begin
         n.on = reg_wdata[ON_BIT];
         n.chan = reg_wdata[CH_W-1:0];
      end
      if (wr_mask) begin
         n.mask = reg_wdata[EVT_W-1:0];
      end
      if (wr_evt) begin
         evt_clr = reg_wdata[EVT_W-1:0];
      end

      // sequencer
      case (s.state)
         ST_IDLE: begin
            if (s.on && !halt) begin
               n.state = ST_STAB;
               n.stab = '0;
            end
         end
         ST_STAB: begin
            // analog settling after power-up or halt exit
            if (s.stab == STAB_W'(STAB_CYCLES - 1)) begin
               n.state = ST_SAMPLE;
               n.cnt = '0;
               evt_set[EVT_READY] = 1'b1;
            end else begin
               n.stab = s.stab + STAB_W'(1);
            end
         end
         ST_SAMPLE: begin
            n.cnt = s.cnt + CNT_W'(1);
            if (s.cnt == CNT_W'(SAMPLE_CYC - 1)) begin
               n.state = ST_CONVERT;
               n.sar = SAR_MSB;
            end
         end
         ST_CONVERT: begin
            n.cnt = s.cnt + CNT_W'(1);
            // comparator gets three cycles through its synchroniser before the decision
            if (phase == BIT_SH'(BIT_CYC - 1)) begin
               if (!s.cmp_s2) begin
                  sar_dec[bit_idx] = 1'b0;
               end
               n.sar = sar_dec;
               if (bit_idx != '0) begin
                  n.sar[bit_idx - CH_W'(1)] = 1'b1;
               end
            end
            if (done) begin
               n.result = sar_dec;
               n.coco = 1'b1;
               n.state = ST_SAMPLE;
               n.cnt = '0;
               if (s.coco && !rd_res) begin
                  evt_set[EVT_OVERRUN] = 1'b1;
               end
            end
         end
         default: begin
            n.state = ST_IDLE;
         end
      endcase

      // control/status write restarts a running conversion
      if (wr_csr && (s.state == ST_SAMPLE || s.state == ST_CONVERT)) begin
         n.state = ST_SAMPLE;
         n.cnt = '0;
         n.sar = s.sar;
         evt_set[EVT_ABORT] = 1'b1;
      end

      // off or halt parks the sequencer; result keeps its value, the flag too under halt (the control write that turns off clears it)
      if (!n.on || halt) begin
         n.state = ST_IDLE;
         n.cnt = '0;
      end

      // set wins over a clear in the same cycle
      n.evt = (s.evt & ~evt_clr) | evt_set;
      n.irq = |(n.evt & n.mask);
      n.sample = (n.state == ST_SAMPLE);
      n.pwr = n.on && !halt;
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign reg_rdata = s.rdata;
   assign channel_select = s.chan;
   assign trial_code = s.sar;
   assign sample_en = s.sample;
   assign converter_power = s.pwr;
   assign irq = s.irq;

   // ****************************************
   // checks
   // ****************************************
   // cycles since the current conversion started sampling
   always_ff @(posedge mclk) begin
      if (reset) begin
         age_r <= '0;
      end else if (s.state == ST_SAMPLE && s.cnt == '0) begin
         age_r <= CNT_W'(1);
      end else begin
         age_r <= age_r + CNT_W'(1);
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);

   coco_set_a:
   assert property (done |=> s.coco)
      else $error("complete flag not set after a conversion");

   coco_clear_a:
   assert property ((wr_csr || (rd_res && !done)) |=> !s.coco)
      else $error("complete flag survived a result read or control write");

   on_bit_a:
   assert property (wr_csr |=> s.on == $past(reg_wdata[ON_BIT])
      && converter_power == (s.on && !$past(halt)))
      else $error("converter-on bit did not follow the write");

   zero_bits_a:
   assert property ((reg_rd && reg_addr == CSR_ADDR) |=> reg_rdata[ZERO4_BIT] == 1'b0
      && reg_rdata[RSV6_BIT] == 1'b0 && reg_rdata[RSV3_BIT] == 1'b0)
      else $error("forced zero bits read back set");

   chan_sel_a:
   assert property (wr_csr |=> channel_select == $past(reg_wdata[CH_W-1:0]))
      else $error("channel select did not follow the write");

   result_read_a:
   assert property (rd_res |=> reg_rdata == $past(s.result)
      ##1 (reg_rdata == REG_RESET || $past(reg_rd)))
      else $error("result read returned wrong data");

   result_ro_a:
   assert property ((reg_wr && reg_addr == RESULT_ADDR && !done) |=> $stable(s.result))
      else $error("result register changed on a write");

   conv_len_a:
   assert property (done |-> age_r == CNT_W'(CONV_CYC - 1))
      else $error("conversion did not take 64 cycles");

   sample_len_a:
   assert property (($fell(sample_en) && s.state == ST_CONVERT)
      |-> age_r == CNT_W'(SAMPLE_CYC))
      else $error("sampling phase did not take 32 cycles");

   continuous_a:
   assert property ((done && s.on) |=> s.state == ST_SAMPLE && s.cnt == '0
      && sample_en && !$rose(irq))
      else $error("no new conversion after completion");

   abort_restart_a:
   assert property ((wr_csr && reg_wdata[ON_BIT] && !halt && s.state != ST_IDLE
      && s.state != ST_STAB) |=> s.state == ST_SAMPLE && s.cnt == '0 && !s.coco)
      else $error("control write did not restart the conversion");

   halt_stop_a:
   assert property (halt |=> s.state == ST_IDLE && !sample_en && !converter_power)
      else $error("conversion ran during halt");

   msb_first_a:
   assert property ((s.state == ST_SAMPLE && n.state == ST_CONVERT) |=> trial_code == SAR_MSB)
      else $error("approximation did not start from the msb");

   result_load_a:
   assert property (!done |=> $stable(s.result))
      else $error("result loaded before all bits settled");

   off_hold_a:
   assert property ((!s.on && !wr_csr) |=> s.state == ST_IDLE && $stable(s.result)
      && (s.coco == $past(s.coco) || !s.coco))
      else $error("sequencer moved while off");

endmodule : adcc_top

`default_nettype wire

//--- bench/adcc_afe_model.sv
// adcc_afe_model: analog mux and comparator seen by the converter control block
`timescale 1ns/1ps
`default_nettype none

module adcc_afe_model (
   // clock
   input wire logic mclk,
   // input levels, input 0 in the low byte
   input wire logic [63:0] levels,
   // from the sequencer
   input wire logic [2:0] channel_select,
   input wire logic [7:0] trial_code,
   input wire logic converter_power,
   // comparator
   output logic cmp_hi
);
   logic junk_r = 1'b0;

   // an unpowered comparator gives no stable answer
   always_ff @(posedge mclk) begin
      junk_r <= ~junk_r;
   end

   always_comb begin
      if (converter_power) begin
         cmp_hi = (levels[channel_select*8 +: 8] >= trial_code);
      end else begin
         cmp_hi = junk_r;
      end
   end
endmodule : adcc_afe_model

`default_nettype wire

//--- bench/adc_control_status_logic_tb.sv
// adc_control_status_logic_tb: self-checking bench of the converter control block
`timescale 1ns/1ps
`default_nettype none

module adc_control_status_logic_tb;
   import adcc_pkg::*;
   logic mclk, reset, reg_wr, reg_rd, halt, cmp_hi, sample_en, converter_power, irq;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, trial_code, rd_v;
   logic [2:0] channel_select;
   logic [63:0] levels = 64'hC3AA5501_7F80FF00;
   int failures, checks, n;

   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   adcc_top #(.STAB_CYCLES(8)) i_dut (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .halt(halt), .cmp_hi(cmp_hi), .channel_select(channel_select),
      .trial_code(trial_code), .sample_en(sample_en),
      .converter_power(converter_power), .irq(irq));

   adcc_afe_model i_afe (.mclk(mclk), .levels(levels), .channel_select(channel_select),
      .trial_code(trial_code), .converter_power(converter_power), .cmp_hi(cmp_hi));

   // ****
   // helpers
   // ****
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic print_verdict;
      $display("failures %0d checks %0d", failures, checks);
      if (failures == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : print_verdict

   task automatic idle(input int c);
      repeat (c) @(posedge mclk);
      #1;
   endtask : idle

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      rd_v = reg_rdata;
   endtask : rd

   // bounded poll of the completion flag
   task automatic wait_done;
      for (int i = 0; i < 200; i++) begin
         rd(CSR_ADDR);
         if (rd_v[7] === 1'b1) return;
      end
      failures++;
      $display("CHECK FAILED completion flag expected 1 seen 0");
      print_verdict();
   endtask : wait_done

   task automatic count_lvl(input logic lvl, input int lim, output int c);
      c = 0;
      while (sample_en === lvl && c < lim) begin
         @(posedge mclk);
         #1;
         c++;
      end
   endtask : count_lvl

   // ****
   // scenarios
   // ****
   task automatic t_reset;
      chk("outputs reset", 8'h00, {3'h0, channel_select, converter_power, sample_en});
      rd(RESULT_ADDR);
      chk("result reset", 8'h00, rd_v);
      rd(CSR_ADDR);
      chk("control reset", 8'h00, rd_v);
      rd(8'h74);
      chk("unmapped read", 8'h00, rd_v);
      chk("irq reset", 8'h00, {7'h00, irq});
   endtask : t_reset

   // bits 6 and 3 written as zero, bit 4 written as one
   task automatic t_channels;
      for (int ch = 0; ch < 8; ch++) begin
         wr(CSR_ADDR, 8'h30 | 8'(ch));
         rd(CSR_ADDR);
         chk("control readback", 8'h20 | 8'(ch), rd_v);
         chk("channel select", 8'(ch), {5'h00, channel_select});
         wait_done();
         chk("flag set", 8'hA0 | 8'(ch), rd_v);
         rd(RESULT_ADDR);
         chk("result", levels[ch*8 +: 8], rd_v);
         rd(CSR_ADDR);
         chk("flag after result read", 8'h20 | 8'(ch), rd_v);
      end
   endtask : t_channels

   task automatic t_timing;
      count_lvl(1'b1, 300, n);
      count_lvl(1'b0, 300, n);
      count_lvl(1'b1, 300, n);
      chk("sampling cycles", 8'h20, n[7:0]);
      count_lvl(1'b0, 300, n);
      chk("resolve cycles", 8'h20, n[7:0]);
   endtask : t_timing

   task automatic t_off;
      rd(RESULT_ADDR);
      wr(CSR_ADDR, 8'h03);
      rd(CSR_ADDR);
      chk("off readback", 8'h03, rd_v);
      idle(150);
      chk("power off", 8'h00, {6'h00, converter_power, sample_en});
      rd(RESULT_ADDR);
      chk("result held", 8'hC3, rd_v);
      rd(CSR_ADDR);
      chk("flag held", 8'h03, rd_v);
      wr(RESULT_ADDR, 8'h5A);
      rd(RESULT_ADDR);
      chk("result read only", 8'hC3, rd_v);
      wr(8'h74, 8'hFF);
      rd(8'h74);
      chk("unmapped write", 8'h00, rd_v);
   endtask : t_off

   task automatic t_halt;
      wr(CSR_ADDR, 8'h25);
      wait_done();
      rd(RESULT_ADDR);
      chk("result before halt", 8'h55, rd_v);
      @(posedge mclk);
      halt <= 1'b1;
      idle(3);
      chk("halt power", 8'h00, {7'h00, converter_power});
      count_lvl(1'b0, 100, n);
      chk("halt no sampling", 8'h64, n[7:0]);
      rd(CSR_ADDR);
      chk("halt no completion", 8'h25, rd_v);
      @(posedge mclk);
      halt <= 1'b0;
      wait_done();
      rd(RESULT_ADDR);
      chk("result after halt", 8'h55, rd_v);
   endtask : t_halt

   // limitation: a conversion may or may not complete before the restart, so only the abort bit is judged
   task automatic t_irq;
      wr(CSR_ADDR, 8'h00);
      wr(EVT_ADDR, 8'h07);
      wr(CSR_ADDR, 8'h20);
      idle(180);
      rd(EVT_ADDR);
      chk("events ready overrun", 8'h06, rd_v);
      chk("irq masked", 8'h00, {7'h00, irq});
      wr(MASK_ADDR, 8'h02);
      idle(3);
      chk("irq raised", 8'h01, {7'h00, irq});
      rd(RESULT_ADDR);
      wr(EVT_ADDR, 8'h07);
      idle(3);
      chk("irq cleared", 8'h00, {7'h00, irq});
      wr(CSR_ADDR, 8'h20);
      rd(EVT_ADDR);
      chk("abort event", 8'h01, rd_v & 8'h01);
      wr(MASK_ADDR, 8'h01);
      idle(3);
      chk("irq abort", 8'h01, {7'h00, irq});
      wr(EVT_ADDR, 8'h01);
      idle(3);
      chk("irq abort cleared", 8'h00, {7'h00, irq});
   endtask : t_irq

   initial begin
      failures = 0;
      checks = 0;
      reset = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      halt = 1'b0;
      repeat (8) @(posedge mclk);
      reset <= 1'b0;
      t_reset();
      t_channels();
      t_timing();
      t_off();
      t_halt();
      t_irq();
      print_verdict();
   end
endmodule : adc_control_status_logic_tb

`default_nettype wire
